// File: csr_command_status.sv
`timescale 1ns/1ps
`default_nettype none
module csr_command_status #(
   parameter logic [csr_pkg::BASE_FIELD_W-1:0] DEF_BASE_FIELD = 10'h000,
   parameter logic [csr_pkg::SMALL_ID_W-1:0]   DEF_SMALL_ID   = 8'h00,
   parameter logic [csr_pkg::LARGE_ID_W-1:0]   DEF_LARGE_ID   = 16'h0000,
   parameter logic                             LARGE_SYS_EN   = 1'b1
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // maintenance configuration port
   input  wire csr_pkg::csr_maint_req_t maintReq,
   output logic                        maintReady,
   // normal read and write path
   input  wire csr_pkg::csr_norm_req_t  normReq,
   output logic                        normHit,
   output logic                        normReady,
   // answers
   output csr_pkg::csr_rsp_t           rsp,
   // current state
   output logic [csr_pkg::BASE_FIELD_W-1:0] configWindowBase,
   output logic [csr_pkg::SMALL_ID_W-1:0]   smallNodeId,
   output logic [csr_pkg::LARGE_ID_W-1:0]   largeNodeId,
   output logic [csr_pkg::OWNER_W-1:0]      ownerHostId,
   output logic                             hostLocked,
   output logic [csr_pkg::DATA_W-1:0]       componentLabel
);

   // ==========================================================
   // request selection
   logic                          winHit;
   logic [csr_pkg::OFS_W-1:0]     winOffset;
   logic                          selValid;
   logic                          selWrite;
   logic                          selNormal;
   logic [csr_pkg::OFS_W-1:0]     selOfs;
   logic [csr_pkg::DATA_W-1:0]    selData;
   logic [csr_pkg::BE_W-1:0]      selBe;
   logic                          selWr;

   csr_window_match u_match (
      .baseField (configWindowBase),
      .addr      (normReq.addr),
      .hit       (winHit),
      .winOffset (winOffset)
   );

   // maintenance always wins; a hitting normal access waits as long as
   // maintReq.valid is high rather than being dropped
   assign maintReady = 1'b1; // [RULE_01]
   assign normHit    = normReq.valid && winHit; // [RULE_05]
   assign normReady  = !maintReq.valid;

   always_comb begin
      selValid  = 1'b0;
      selWrite  = 1'b0;
      selNormal = 1'b0;
      selOfs    = '0;
      selData   = '0;
      selBe     = '0;
      if (maintReq.valid) begin
         selValid = 1'b1;
         selWrite = maintReq.write;
         selOfs   = maintReq.offset;
         selData  = maintReq.wdata;
         selBe    = maintReq.be;
      end else if (normHit) begin
         selValid  = 1'b1; // [RULE_07]
         selWrite  = normReq.write;
         selNormal = 1'b1;
         selOfs    = winOffset;
         selData   = normReq.wdata;
         selBe     = normReq.be;
      end
   end

   assign selWr = selValid && selWrite;

   // ==========================================================
   // write strobes
   logic wrLowBase;
   logic wrNodeId;
   logic wrHostLock;
   logic wrLabel;

   assign wrLowBase  = selWr
                       && csr_pkg::ofs_is(selOfs, csr_pkg::OFS_LOW_BASE);
   assign wrNodeId   = selWr
                       && csr_pkg::ofs_is(selOfs, csr_pkg::OFS_NODE_ID);
   assign wrHostLock = selWr
                       && csr_pkg::ofs_is(selOfs, csr_pkg::OFS_HOST_LOCK);
   assign wrLabel    = selWr
                       && csr_pkg::ofs_is(selOfs, csr_pkg::OFS_LABEL);

   // ==========================================================
   // low configuration base
   logic [csr_pkg::DATA_W-1:0] baseMerged;

   assign baseMerged = csr_pkg::merge_bytes(
      {1'b0, configWindowBase, 21'h00_0000}, selData, selBe);

   always_ff @(posedge clk) begin
      if (srst) begin
         configWindowBase <= DEF_BASE_FIELD; // [RULE_04]
      end else if (wrLowBase) begin
         // the new base is compared from the next cycle on
         configWindowBase <= baseMerged[csr_pkg::BASE_FIELD_LSB +:
                                        csr_pkg::BASE_FIELD_W]; // [RULE_06]
      end
   end

   // ==========================================================
   // base node identifiers
   logic [csr_pkg::DATA_W-1:0] nodeMerged;

   assign nodeMerged = csr_pkg::merge_bytes(
      {8'h00, smallNodeId, largeNodeId}, selData, selBe);

   always_ff @(posedge clk) begin
      if (srst) begin
         smallNodeId <= DEF_SMALL_ID; // [RULE_08]
      end else if (wrNodeId) begin
         smallNodeId <= nodeMerged[csr_pkg::SMALL_ID_LSB +:
                                   csr_pkg::SMALL_ID_W]; // [RULE_08]
      end
   end

   // without large-system support the low half is reserved
   always_ff @(posedge clk) begin
      if (srst) begin
         largeNodeId <= LARGE_SYS_EN ? DEF_LARGE_ID : 16'h0000;
      end else if (wrNodeId && LARGE_SYS_EN) begin
         largeNodeId <= nodeMerged[csr_pkg::LARGE_ID_W-1:0]; // [RULE_08]
      end
   end

   // ==========================================================
   // host lock
   csr_host_lock u_lock (
      .clk         (clk),
      .srst        (srst),
      .wrEn        (wrHostLock),
      .wrData      (selData[csr_pkg::OWNER_W-1:0]),
      .wrBe        (selBe[1:0]),
      .ownerHostId (ownerHostId),
      .locked      (hostLocked)
   );

   // ==========================================================
   // component label
   always_ff @(posedge clk) begin
      if (srst) begin
         componentLabel <= csr_pkg::LABEL_RESET; // [RULE_13]
      end else if (wrLabel) begin
         componentLabel <= csr_pkg::merge_bytes(
            componentLabel, selData, selBe); // [RULE_13]
      end
   end

   // ==========================================================
   // read mux
   logic [csr_pkg::DATA_W-1:0] readValue;

   // writes to fixed or reserved words fall through with no strobe
   always_comb begin
      readValue = '0; // [RULE_14]
      if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_LOGICAL_CTRL)) begin
         readValue = csr_pkg::LOGICAL_CTRL_VALUE; // [RULE_02]
      end else if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_HIGH_BASE)) begin
         readValue = csr_pkg::HIGH_BASE_VALUE; // [RULE_03]
      end else if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_LOW_BASE)) begin
         readValue = {1'b0, configWindowBase, 21'h00_0000}; // [RULE_06]
      end else if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_NODE_ID)) begin
         readValue = {8'h00, smallNodeId, largeNodeId}; // [RULE_09]
      end else if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_HOST_LOCK)) begin
         readValue = {16'h0000, ownerHostId};
      end else if (csr_pkg::ofs_is(selOfs, csr_pkg::OFS_LABEL)) begin
         readValue = componentLabel;
      end
   end

   // ==========================================================
   // answer register
   always_ff @(posedge clk) begin
      if (srst) begin
         rsp <= '0;
      end else begin
         rsp.valid      <= selValid;
         rsp.write      <= selWrite;
         rsp.fromNormal <= selNormal;
         // a write answer carries zero data, not the old value
         rsp.rdata      <= (selValid && !selWrite) ? readValue : '0;
      end
   end

endmodule
`default_nettype wire

// File: csr_command_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module csr_command_status_props #(
   parameter logic [9:0] DEF_BASE_FIELD = 10'h000,
   parameter logic [7:0] DEF_SMALL_ID   = 8'h00
) (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    srst,
   // requests
   input wire csr_pkg::csr_maint_req_t maintReq,
   input wire csr_pkg::csr_norm_req_t  normReq,
   // answers and state
   input wire logic                    normHit,
   input wire csr_pkg::csr_rsp_t       rsp,
   input wire logic [9:0]              configWindowBase,
   input wire logic [7:0]              smallNodeId,
   input wire logic [15:0]             ownerHostId,
   input wire logic                    hostLocked,
   input wire logic [31:0]             componentLabel
);
   // =====
   // helpers
   logic        mw;
   logic        mr;
   logic [21:0] mo;
   assign mw = maintReq.valid && maintReq.write;
   assign mr = maintReq.valid && !maintReq.write;
   assign mo = maintReq.offset[23:2];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // =====
   // properties
   ctrl_read_a: assert property (
      mr && mo == 22'h13 |=> rsp.valid && rsp.rdata == 32'h0000_0001)
      else $error("control register read wrong");
   high_read_a: assert property (
      mr && mo == 22'h16 |=> rsp.valid && rsp.rdata == 32'h0000_0000)
      else $error("high base read not zero");
   window_hit_a: assert property (
      normHit == (normReq.valid && normReq.addr[34:25] == configWindowBase))
      else $error("window compare wrong");
   base_load_a: assert property (
      mw && mo == 22'h17 && maintReq.be == 4'hF
      |=> configWindowBase == $past(maintReq.wdata[30:21]))
      else $error("base field not loaded");
   label_load_a: assert property (
      mw && mo == 22'h1B && maintReq.be == 4'hF
      |=> componentLabel == $past(maintReq.wdata))
      else $error("label not loaded");
   id_read_a: assert property (
      mr && mo == 22'h18 |=> rsp.rdata[31:16] == {8'h00, smallNodeId})
      else $error("node id read wrong");
   reset_vals_a: assert property (
      $past(srst) |-> ownerHostId == 16'hFFFF && !hostLocked
      && componentLabel == 32'h0 && configWindowBase == DEF_BASE_FIELD
      && smallNodeId == DEF_SMALL_ID)
      else $error("reset values wrong");
   lock_hold_a: assert property (
      hostLocked && !normHit && !(mw && mo == 22'h1A
      && maintReq.wdata[15:0] == ownerHostId) |=> $stable(ownerHostId))
      else $error("locked owner changed");
   owner_unlock_a: assert property (
      hostLocked && mw && mo == 22'h1A && maintReq.be[1:0] == 2'b11
      && maintReq.wdata[15:0] == ownerHostId
      |=> ownerHostId == 16'hFFFF && !hostLocked)
      else $error("matching write did not unlock");
   ones_nolock_a: assert property (
      !hostLocked && mw && mo == 22'h1A && maintReq.wdata[15:0] == 16'hFFFF
      |=> !hostLocked)
      else $error("all ones write locked");
endmodule
bind csr_command_status csr_command_status_props #(
   .DEF_BASE_FIELD(DEF_BASE_FIELD), .DEF_SMALL_ID(DEF_SMALL_ID)
) u_props (
   .clk(clk), .srst(srst), .maintReq(maintReq), .normReq(normReq),
   .normHit(normHit), .rsp(rsp), .configWindowBase(configWindowBase),
   .smallNodeId(smallNodeId), .ownerHostId(ownerHostId),
   .hostLocked(hostLocked), .componentLabel(componentLabel));
`default_nettype wire

// File: csr_command_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
   err_count++; $display("Error at %0t: got %h exp %h", $time, a, b); \
   end end
module csr_command_status_tb;
   // =====
   // signals
   localparam logic [9:0]  BASE0 = 10'h2A5;
   localparam logic [7:0]  SID   = 8'h5A;
   localparam logic [15:0] LID   = 16'hC3E1;
   logic                    clk  = 1'b0;
   logic                    srst = 1'b1;
   logic                    normHit, normReady, hostLocked;
   logic                    maintReady;
   logic [7:0]              smallId;
   logic [15:0]             largeId, largeOff;
   logic [9:0]              base;
   logic [15:0]             owner;
   logic [31:0]             label;
   csr_pkg::csr_maint_req_t maintReq;
   csr_pkg::csr_norm_req_t  normReq;
   csr_pkg::csr_rsp_t       rsp;
   int                      err_count = 0;
   int                      checks_done = 0;
   logic [23:0]             ofs [8] = '{24'h4C, 24'h58, 24'h5C, 24'h60,
                                        24'h64, 24'h68, 24'h6C, 24'h70};
   always #4 clk = ~clk;
   csr_command_status #(.DEF_BASE_FIELD(BASE0), .DEF_SMALL_ID(SID),
      .DEF_LARGE_ID(LID), .LARGE_SYS_EN(1'b1)) dut (
      .clk(clk), .srst(srst), .maintReq(maintReq), .maintReady(maintReady),
      .normReq(normReq), .normHit(normHit), .normReady(normReady),
      .rsp(rsp), .configWindowBase(base), .smallNodeId(smallId),
      .largeNodeId(largeId), .ownerHostId(owner), .hostLocked(hostLocked),
      .componentLabel(label));
   // a second copy without large-system support sees the same requests
   csr_command_status #(.DEF_SMALL_ID(SID), .DEF_LARGE_ID(LID),
      .LARGE_SYS_EN(1'b0)) dut_small (
      .clk(clk), .srst(srst), .maintReq(maintReq), .maintReady(),
      .normReq(normReq), .normHit(), .normReady(), .rsp(),
      .configWindowBase(), .smallNodeId(), .largeNodeId(largeOff),
      .ownerHostId(), .hostLocked(), .componentLabel());
   csr_fabric_model fab (.clk(clk), .maintReq(maintReq), .normReq(normReq),
      .normHit(normHit), .normReady(normReady), .rsp(rsp));
   // =====
   // scenarios
   task automatic rd_all(input logic [31:0] e [8]);
      csr_pkg::csr_rsp_t r;
      for (int i = 0; i < 8; i++) begin
         fab.mt(1'b0, ofs[i], 32'h0, 4'h0, r);
         `CHK(r.rdata, e[i])
      end
   endtask
   task automatic t_reset();
      rd_all('{32'h1, 32'h0, {1'b0, BASE0, 21'h0}, {8'h0, SID, LID}, 32'h0,
               32'h0000_FFFF, 32'h0, 32'h0});
      `CHK({smallId, largeId, largeOff}, {SID, LID, 16'h0})
   endtask
   // all ones everywhere exposes every stuck or reserved bit at once
   task automatic t_ones();
      csr_pkg::csr_rsp_t r;
      for (int i = 0; i < 8; i++) fab.mt(1'b1, ofs[i], 32'hFFFF_FFFF, 4'hF, r);
      `CHK(hostLocked, 1'b0)
      rd_all('{32'h1, 32'h0, 32'h7FE0_0000, 32'h00FF_FFFF, 32'h0,
               32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0});
      `CHK({smallId, largeId, largeOff}, 40'hFF_FFFF_0000)
   endtask
   task automatic t_window();
      csr_pkg::csr_rsp_t r;
      logic              h;
      fab.nt(1'b1, {10'h3FF, 25'h6C}, 32'h1357_9BDF, h, r);
      `CHK({h, r.fromNormal, label}, {2'b11, 32'h1357_9BDF})
      fab.nt(1'b1, {10'h3FF, 25'h5C}, 32'h0AA0_0000, h, r);
      `CHK(base, 10'h055)
      fab.nt(1'b0, {10'h3FF, 25'h6C}, 32'h0, h, r);
      `CHK({h, r.valid}, 2'b00)
      fab.nt(1'b0, {10'h055, 25'h6C}, 32'h0, h, r);
      `CHK({h, r.valid, r.rdata}, {2'b11, 32'h1357_9BDF})
   endtask
   // both ports at once: maintenance first, the hitting read waits
   task automatic t_stall();
      csr_pkg::csr_rsp_t rm;
      csr_pkg::csr_rsp_t rn;
      logic              h;
      fork
         fab.mt(1'b1, 24'h6C, 32'h2468_ACE0, 4'hF, rm);
         fab.nt(1'b0, {10'h055, 25'h6C}, 32'h0, h, rn);
      join
      `CHK(maintReady, 1'b1)
      `CHK({rm.valid, rm.write, rm.fromNormal}, 3'b110)
      `CHK(rm.rdata, 32'h0)
      `CHK({h, rn.valid, rn.write, rn.fromNormal}, 4'b1101)
      `CHK(rn.rdata, 32'h2468_ACE0)
   endtask
   task automatic t_lock();
      csr_pkg::csr_rsp_t r;
      logic [15:0] v [6] = '{16'h1234, 16'h5678, 16'h1234, 16'h1234,
                             16'hFFFF, 16'hABCD};
      logic [3:0]  be [6] = '{4'h3, 4'h3, 4'h1, 4'h3, 4'h3, 4'h3};
      logic [15:0] e [6] = '{16'h1234, 16'h1234, 16'h1234, 16'hFFFF,
                             16'hFFFF, 16'hABCD};
      for (int i = 0; i < 6; i++) begin
         fab.mt(1'b1, 24'h68, {16'hFFFF, v[i]}, be[i], r);
         `CHK({owner, hostLocked}, {e[i], e[i] != 16'hFFFF})
      end
      fab.mt(1'b0, 24'h68, 32'h0, 4'h0, r);
      `CHK(r.rdata, 32'h0000_ABCD)
   endtask
   // =====
   // run control
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_ones();
      t_window();
      t_stall();
      t_lock();
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      t_reset();
      summarize();
   end
   // the run needs about 100 cycles; this allows a wide margin
   initial begin
      #40000;
      err_count++;
      summarize();
   end
endmodule
`default_nettype wire

// File: csr_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module csr_fabric_model (
   // clock
   input  wire logic                   clk,
   // requests
   output var csr_pkg::csr_maint_req_t maintReq,
   output var csr_pkg::csr_norm_req_t  normReq,
   // answers
   input  wire logic                   normHit,
   input  wire logic                   normReady,
   input  wire csr_pkg::csr_rsp_t      rsp
);
   // =====
   // request tasks
   initial begin
      maintReq = '0;
      normReq  = '0;
   end
   // released lines show inverted values so stale data never looks valid
   task automatic mt(input logic w, input logic [23:0] o,
         input logic [31:0] d, input logic [3:0] be,
         output csr_pkg::csr_rsp_t r);
      @(posedge clk);
      maintReq <= '{1'b1, w, o, d, be};
      @(posedge clk);
      maintReq <= '{1'b0, 1'b0, ~o, ~d, ~be};
      #1 r = rsp;
   endtask
   task automatic nt(input logic w, input logic [34:0] a,
         input logic [31:0] d, output logic h,
         output csr_pkg::csr_rsp_t r);
      @(posedge clk);
      normReq <= '{1'b1, w, a, d, 4'hF};
      #1 h = normHit;
      // a hitting access is held while maintenance has the port
      @(posedge clk);
      while (h && !normReady) @(posedge clk);
      normReq <= '{1'b0, 1'b0, ~a, ~d, 4'h0};
      #1 r = rsp;
   endtask
endmodule
`default_nettype wire

// File: csr_host_lock.sv
`timescale 1ns/1ps
`default_nettype none
module csr_host_lock (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        srst,
   // write strobe
   input  wire logic                        wrEn,
   input  wire logic [csr_pkg::OWNER_W-1:0] wrData,
   input  wire logic [1:0]                  wrBe,
   // state
   output logic [csr_pkg::OWNER_W-1:0]      ownerHostId,
   output logic                             locked
);

   logic fullWrite;

   assign fullWrite = wrBe == 2'b11;
   // all ones is the free state, so writing it cannot lock
   assign locked = ownerHostId != csr_pkg::OWNER_RESET; // [RULE_12]

   // ==========================================================
   // owner field
   always_ff @(posedge clk) begin
      if (srst) begin
         ownerHostId <= csr_pkg::OWNER_RESET; // [RULE_10]
      end else if (wrEn && fullWrite) begin
         if (!locked) begin
            ownerHostId <= wrData; // [RULE_10]
         end else if (wrData == ownerHostId) begin
            ownerHostId <= csr_pkg::OWNER_RESET; // [RULE_11]
         end
      end
   end

endmodule
`default_nettype wire

// File: csr_pkg.sv
// Summary of operation
// RULE_01 - fabric sends command space accesses here
// RULE_02 - addressing control reads fixed 34-bit code
// RULE_03 - high base reads zero, ignores writes
// RULE_04 - low base loads from either write path
// RULE_05 - new base steers later normal compares
// RULE_06 - only base bits 30:21 writable, compared
// RULE_07 - base matches address bits 34:25
// RULE_08 - small and large node ids writable
// RULE_09 - node id reserved bits read zero
// RULE_10 - owner id resets ones, locks once
// RULE_11 - matching full write unlocks owner id
// RULE_12 - writing all ones never locks
// RULE_13 - component label fully read-write
// RULE_14 - reserved offsets read zero, ignore writes
package csr_pkg;

   // ==========================================================
   // widths
   localparam int OFS_W  = 24;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int ADDR_W = 35;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [OFS_W-1:0] OFS_LOGICAL_CTRL = 24'h00_004C;
   localparam logic [OFS_W-1:0] OFS_HIGH_BASE    = 24'h00_0058;
   localparam logic [OFS_W-1:0] OFS_LOW_BASE     = 24'h00_005C;
   localparam logic [OFS_W-1:0] OFS_NODE_ID      = 24'h00_0060;
   localparam logic [OFS_W-1:0] OFS_HOST_LOCK    = 24'h00_0068;
   localparam logic [OFS_W-1:0] OFS_LABEL        = 24'h00_006C;

   // ==========================================================
   // fixed values and reset values
   localparam logic [DATA_W-1:0] LOGICAL_CTRL_VALUE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] HIGH_BASE_VALUE    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] LABEL_RESET        = 32'h0000_0000;
   localparam logic [15:0]       OWNER_RESET        = 16'hFFFF;

   // ==========================================================
   // field positions
   localparam int BASE_FIELD_LSB = 21;
   localparam int BASE_FIELD_W   = 10;
   localparam int WIN_ADDR_LSB   = 25;
   localparam int WIN_OFS_W      = 24;
   localparam int SMALL_ID_LSB   = 16;
   localparam int SMALL_ID_W     = 8;
   localparam int LARGE_ID_W     = 16;
   localparam int OWNER_W        = 16;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [OFS_W-1:0]  offset;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0]   be;
   } csr_maint_req_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0]   be;
   } csr_norm_req_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic              fromNormal;
      logic [DATA_W-1:0] rdata;
   } csr_rsp_t;

   // ==========================================================
   // helpers
   function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] oldVal,
      input logic [DATA_W-1:0] newVal,
      input logic [BE_W-1:0]   be
   );
      logic [DATA_W-1:0] res;
      res = oldVal;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // word-aligned offset compare; byte lane bits are ignored
   function automatic logic ofs_is(
      input logic [OFS_W-1:0] ofs,
      input logic [OFS_W-1:0] target
   );
      return ofs[OFS_W-1:2] == target[OFS_W-1:2];
   endfunction

endpackage

// File: csr_pkg_end_marker_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: csr_window_match.sv
`timescale 1ns/1ps
`default_nettype none
module csr_window_match (
   // base field
   input  wire logic [csr_pkg::BASE_FIELD_W-1:0] baseField,
   // normal address
   input  wire logic [csr_pkg::ADDR_W-1:0]       addr,
   // result
   output logic                                  hit,
   output logic [csr_pkg::OFS_W-1:0]             winOffset
);

   // ==========================================================
   // window compare
   // bit 24 is neither compared nor part of the offset, so the
   // window answers for both of its values
   assign hit = addr[csr_pkg::ADDR_W-1:csr_pkg::WIN_ADDR_LSB]
                == baseField; // [RULE_07] [RULE_06]
   assign winOffset = addr[csr_pkg::WIN_OFS_W-1:0];

endmodule
`default_nettype wire
